/* design/clock_synth_reset_control.sv */
`timescale 1ns/100ps
module clock_synth_reset_control #(
    parameter int unsigned LossCycles = clock_reset_pkg::LOSS_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Clock pins
    input wire logic refClockInput,
    input wire logic vcoIn,
    input wire logic vcoStable,
    input wire clock_reset_pkg::clock_mode_t clockMode,
    output logic systemClockOutput,
    output logic pumpUp,
    output logic pumpDown,
    output logic vcoLocked,
    // Reset pin, open drain
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOeN,
    // Reset sources and bus status
    input wire logic watchdogReset,
    input wire logic doubleBusFault,
    input wire logic resetInstr,
    input wire logic operandBusy,
    input wire logic cycleDone,
    input wire logic lastPortion,
    output logic systemReset
);
    import clock_reset_pkg::*;

    // ========
    // Pin synchronisers
    logic [4:0] pinSync;
    logic refSync, vcoSync, stableSync, rstPinSync;
    logic [1:0] modeSync;
    input_sync #(.WIDTH(5)) u_pins (
        .clock(clock),
        .resetn(resetn),
        .async({refClockInput, vcoIn, vcoStable, resetPinIn, 1'b0}),
        .resetValue(5'h02),
        .synced(pinSync)
    );
    input_sync #(.WIDTH(2)) u_mode (
        .clock(clock),
        .resetn(resetn),
        .async(clockMode),
        .resetValue(2'h0),
        .synced(modeSync)
    );
    assign refSync = pinSync[4];
    assign vcoSync = pinSync[3];
    assign stableSync = pinSync[2];
    assign rstPinSync = pinSync[1];

    logic refPrev_q, vcoPrev_q;
    logic refRise, refFall, vcoTick;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            refPrev_q <= 1'b0;
            vcoPrev_q <= 1'b0;
        end else begin
            refPrev_q <= refSync;
            vcoPrev_q <= vcoSync;
        end
    end
    assign refRise = refSync && !refPrev_q;
    assign refFall = !refSync && refPrev_q;
    assign vcoTick = vcoSync && !vcoPrev_q;

    // ========
    // Registers
    logic prescale_q, postDiv_q, bmEnable_q;
    logic [5:0] mult_q;
    logic [1:0] bmtSel_q;
    logic [5:0] rstSource_q;
    logic softInit;
    logic synthWrite;

    // ========
    // Output divider, outside the loop
    logic [1:0] outDiv_q;
    logic extPll;
    assign extPll = (modeSync == MODE_EXT_VCO);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            outDiv_q <= 2'h0;
        end else if (extPll && refFall) begin
            outDiv_q <= 2'h0;
        end else if (vcoTick) begin
            outDiv_q <= outDiv_q + 2'h1;
        end
    end

    // Free running from reset; lock never gates it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            systemClockOutput <= 1'b0;
        end else if (modeSync == MODE_EXT_NOVCO) begin
            systemClockOutput <= refSync;
        end else begin
            // X only picks the tap, the loop never sees it
            systemClockOutput <= postDiv_q ? outDiv_q[0] :
                outDiv_q[1];
        end
    end

    // ========
    // Feedback divider and phase detector
    logic [FB_CNT_W-1:0] fbCount_q, fbLimit;
    logic fbTick;
    always_comb begin
        fbLimit = FB_CNT_W'({1'b0, mult_q} + 7'h01) << FB_BASE_SHIFT;
        if (prescale_q) begin
            fbLimit = fbLimit << 2;
        end
    end
    assign fbTick = vcoTick && (fbCount_q == fbLimit - 1'b1);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fbCount_q <= '0;
        end else if (fbTick || synthWrite) begin
            fbCount_q <= '0;
        end else if (vcoTick) begin
            fbCount_q <= fbCount_q + 1'b1;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pumpUp <= 1'b0;
            pumpDown <= 1'b0;
        end else if (modeSync == MODE_EXT_NOVCO) begin
            pumpUp <= 1'b0;
            pumpDown <= 1'b0;
        end else if (refFall && fbTick) begin
            pumpUp <= 1'b0;
            pumpDown <= 1'b0;
        end else if (refFall) begin
            pumpUp <= !pumpDown;
            pumpDown <= 1'b0;
        end else if (fbTick) begin
            pumpDown <= !pumpUp;
            pumpUp <= 1'b0;
        end
    end

    // ========
    // Lock delay
    logic refSeen_q, lockStart, locked;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            refSeen_q <= 1'b0;
        end else if (refRise) begin
            refSeen_q <= 1'b1;
        end
    end
    assign lockStart = (modeSync == MODE_EXT_NOVCO) ? refSeen_q :
        stableSync;
    lock_delay u_lock (
        .clock(clock),
        .resetn(resetn),
        .restart(synthWrite),
        .startLevel(lockStart),
        .refTick(refRise),
        .locked(locked)
    );
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            vcoLocked <= 1'b0;
        end else begin
            vcoLocked <= locked;
        end
    end

    // ========
    // Loss of reference
    logic [LOSS_CNT_W-1:0] lossCount_q;
    logic clockLost;
    assign clockLost = (lossCount_q == LOSS_CNT_W'(LossCycles));
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lossCount_q <= '0;
        end else if (refRise || !refSeen_q) begin
            lossCount_q <= '0;
        end else if (!clockLost) begin
            lossCount_q <= lossCount_q + 1'b1;
        end
    end

    // ========
    // Reset sequencer
    reset_state_t state_q;
    logic [5:0] pending_q, newReq;
    logic [6:0] bmCount_q, bmLimit;
    logic [4:0] holdCount_q;
    logic lossSeen_q, pinArmed_q, operandDone, fullReset;

    always_comb begin
        case (bmtSel_q)
            2'h0: bmLimit = BUS_MON_64;
            2'h1: bmLimit = BUS_MON_32;
            2'h2: bmLimit = BUS_MON_16;
            default: bmLimit = BUS_MON_8;
        endcase
    end
    assign newReq = {resetInstr, clockLost && !lossSeen_q, doubleBusFault,
                     watchdogReset, 1'b0,
                     !rstPinSync && pinArmed_q && (state_q == RST_IDLE)};
    assign operandDone = !operandBusy || (cycleDone && lastPortion) ||
                         (bmCount_q == bmLimit);
    assign fullReset = |pending_q[SRC_LOC:SRC_EXT];
    assign softInit = (state_q == RST_DEFER) && operandDone && fullReset;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lossSeen_q <= 1'b0;
        end else begin
            lossSeen_q <= clockLost;
        end
    end

    // Our own drive echoes back through the synchroniser after the gap
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pinArmed_q <= 1'b1;
        end else begin
            pinArmed_q <= (state_q != RST_DRIVE) &&
                          (pinArmed_q || rstPinSync);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= RST_IDLE;
            pending_q <= 6'h0;
            bmCount_q <= 7'h0;
            holdCount_q <= 5'h0;
        end else begin
            case (state_q)
                RST_IDLE: begin
                    bmCount_q <= 7'h0;
                    pending_q <= newReq;
                    if (|newReq) begin
                        state_q <= RST_DEFER;
                    end
                end
                RST_DEFER: begin
                    // Runs regardless of the monitor enable bit
                    bmCount_q <= bmCount_q + 7'h01;
                    pending_q <= pending_q | {newReq[5:1], 1'b0};
                    if (operandDone) begin
                        state_q <= RST_DRIVE;
                        holdCount_q <= 5'h0;
                    end
                end
                RST_DRIVE: begin
                    holdCount_q <= holdCount_q + 5'h01;
                    if (holdCount_q == 5'(DRIVE_CYCLES - 1)) begin
                        state_q <= RST_GAP;
                        holdCount_q <= 5'h0;
                    end
                end
                RST_GAP: begin
                    // Pin released and not sampled while it rises
                    holdCount_q <= holdCount_q + 5'h01;
                    if (holdCount_q == 5'(PIN_GAP_CYCLES - 1)) begin
                        state_q <= RST_IDLE;
                    end
                end
                default: state_q <= RST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            systemReset <= 1'b0;
            resetPinOeN <= 1'b1;
            resetPinOut <= 1'b0;
        end else begin
            // Instruction-only resets touch only the pin
            systemReset <= (state_q == RST_DRIVE) && fullReset;
            resetPinOeN <= !(state_q == RST_DRIVE);
            resetPinOut <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rstSource_q <= SRC_RESET;
        end else if (softInit) begin
            rstSource_q <= pending_q;
        end else if ((state_q == RST_DEFER) && operandDone) begin
            rstSource_q[SRC_INSTR] <= 1'b1;
        end
    end

    // ========
    // AXI4-Lite write
    logic awHeld_q, wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    assign doWrite = awHeld_q && wHeld_q && !bvalid;
    assign synthWrite = doWrite && (awAddr_q == SYNTH_CTRL_OFS) && wStrb_q[1];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            awready <= !awHeld_q && !(awvalid && awready);
            wready <= !wHeld_q && !(wvalid && wready);
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= (awAddr_q == SYNTH_CTRL_OFS ||
                          awAddr_q == RESET_CTRL_OFS ||
                          awAddr_q == RESET_STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prescale_q <= PRESCALE_RESET;
            postDiv_q <= POSTDIV_RESET;
            mult_q <= MULT_RESET;
            bmtSel_q <= BMT_RESET;
            bmEnable_q <= BM_EN_RESET;
        end else if (softInit) begin
            prescale_q <= PRESCALE_RESET;
            postDiv_q <= POSTDIV_RESET;
            mult_q <= MULT_RESET;
            bmtSel_q <= BMT_RESET;
            bmEnable_q <= BM_EN_RESET;
        end else if (doWrite) begin
            if (awAddr_q == SYNTH_CTRL_OFS && wStrb_q[1]) begin
                prescale_q <= wData_q[PRESCALE_BIT];
                postDiv_q <= wData_q[POSTDIV_BIT];
                mult_q <= wData_q[MULT_LSB +: 6];
            end
            if (awAddr_q == RESET_CTRL_OFS && wStrb_q[0]) begin
                bmtSel_q <= wData_q[BMT_LSB +: 2];
                bmEnable_q <= wData_q[BM_EN_BIT];
            end
        end
    end

    // ========
    // AXI4-Lite read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= RESP_OKAY;
                rdata <= 32'h0;
                case (araddr)
                    SYNTH_CTRL_OFS: begin
                        rdata[PRESCALE_BIT] <= prescale_q;
                        rdata[POSTDIV_BIT] <= postDiv_q;
                        rdata[MULT_LSB +: 6] <= mult_q;
                        rdata[LOCK_BIT] <= locked;
                    end
                    RESET_CTRL_OFS: begin
                        rdata[BMT_LSB +: 2] <= bmtSel_q;
                        rdata[BM_EN_BIT] <= bmEnable_q;
                    end
                    RESET_STAT_OFS: rdata[5:0] <= rstSource_q;
                    default: rresp <= RESP_SLVERR;
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule : clock_synth_reset_control

/* design/clock_reset_pkg.sv */
package clock_reset_pkg;
    // ========
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned REF_LOCK_PERIODS = 328;
    localparam int unsigned LOCK_CNT_W = 9;
    localparam int unsigned PIN_GAP_CYCLES = 2;
    localparam int unsigned DRIVE_CYCLES = 16;
    localparam int unsigned LOSS_TIME_NS = 61036;
    localparam int unsigned LOSS_CYCLES = LOSS_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned LOSS_CNT_W = 13;
    localparam int unsigned FB_BASE_SHIFT = 4;
    localparam int unsigned FB_CNT_W = 13;
    // Bus monitor periods indexed by timeout select
    localparam logic [6:0] BUS_MON_64 = 7'h40;
    localparam logic [6:0] BUS_MON_32 = 7'h20;
    localparam logic [6:0] BUS_MON_16 = 7'h10;
    localparam logic [6:0] BUS_MON_8 = 7'h08;

    // ========
    // Register map
    localparam logic [7:0] SYNTH_CTRL_OFS = 8'h00;
    localparam logic [7:0] RESET_CTRL_OFS = 8'h04;
    localparam logic [7:0] RESET_STAT_OFS = 8'h08;
    localparam int unsigned PRESCALE_BIT = 15;
    localparam int unsigned POSTDIV_BIT = 14;
    localparam int unsigned MULT_LSB = 8;
    localparam int unsigned LOCK_BIT = 3;
    localparam int unsigned BMT_LSB = 0;
    localparam int unsigned BM_EN_BIT = 2;
    localparam logic PRESCALE_RESET = 1'h0;
    localparam logic POSTDIV_RESET = 1'h0;
    localparam logic [5:0] MULT_RESET = 6'h3F;
    localparam logic [1:0] BMT_RESET = 2'h0;
    localparam logic BM_EN_RESET = 1'h0;
    // Reset source flags
    localparam int unsigned SRC_EXT = 0;
    localparam int unsigned SRC_POR = 1;
    localparam int unsigned SRC_WDOG = 2;
    localparam int unsigned SRC_DBF = 3;
    localparam int unsigned SRC_LOC = 4;
    localparam int unsigned SRC_INSTR = 5;
    localparam logic [5:0] SRC_RESET = 6'h02;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========
    // Clock modes and reset sequencer
    typedef enum logic [1:0] {
        MODE_CRYSTAL = 2'h0,
        MODE_EXT_VCO = 2'h1,
        MODE_EXT_NOVCO = 2'h2
    } clock_mode_t;

    typedef enum logic [3:0] {
        RST_IDLE = 4'h1,
        RST_DEFER = 4'h2,
        RST_DRIVE = 4'h4,
        RST_GAP = 4'h8
    } reset_state_t;
endpackage : clock_reset_pkg

/* design/input_sync.sv */
`timescale 1ns/100ps
module input_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async,
    input wire logic [WIDTH-1:0] resetValue,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // ========
    // Two flops; only the second one is read outside
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= async ^ resetValue;
            stage2_q <= stage1_q;
        end
    end

    assign synced = stage2_q ^ resetValue;
endmodule : input_sync

/* design/lock_delay.sv */
`timescale 1ns/100ps
module lock_delay (
    input wire logic clock,
    input wire logic resetn,
    input wire logic restart,
    input wire logic startLevel,
    input wire logic refTick,
    output logic locked
);
    import clock_reset_pkg::*;

    logic [LOCK_CNT_W-1:0] count_q;
    logic locked_q;

    // ========
    // Count reference periods once the start condition holds
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
            locked_q <= 1'b0;
        end else if (restart || !startLevel) begin
            count_q <= '0;
            locked_q <= 1'b0;
        end else if (refTick && !locked_q) begin
            if (count_q == LOCK_CNT_W'(REF_LOCK_PERIODS - 1)) begin
                locked_q <= 1'b1;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    assign locked = locked_q;
endmodule : lock_delay

/* bench/clock_synth_reset_control_sva.sv */
`timescale 1ns/100ps
module clock_synth_reset_control_sva (
    input logic clock,
    input logic resetn,
    input logic arvalid,
    input logic arready,
    input logic rvalid,
    input logic rready,
    input logic [31:0] rdata,
    input logic bvalid,
    input logic bready,
    input logic [1:0] bresp,
    input logic vcoStable,
    input clock_reset_pkg::clock_mode_t clockMode,
    input logic vcoLocked,
    input logic systemClockOutput,
    input logic resetPinOut,
    input logic resetPinOeN,
    input logic systemReset
);
    import clock_reset_pkg::*;
    // ========
    // Helper counters
    logic [7:0] lowCnt_q;
    logic [7:0] stillCnt_q;
    logic clkPrev_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lowCnt_q <= 8'h00;
        end else begin
            lowCnt_q <= resetPinOeN ? 8'h00 : lowCnt_q + 8'h01;
        end
    end
    // Saturates so a stuck output cannot wrap back under the bound
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stillCnt_q <= 8'h00;
            clkPrev_q <= 1'b0;
        end else begin
            clkPrev_q <= systemClockOutput;
            if (systemClockOutput != clkPrev_q) begin
                stillCnt_q <= 8'h00;
            end else if (stillCnt_q != 8'hFF) begin
                stillCnt_q <= stillCnt_q + 8'h01;
            end
        end
    end
    // ========
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    a_pin_never_high: assert property (resetPinOut == 1'b0)
        else $error("pin high");
    a_drive_sixteen: assert property (
        $rose(resetPinOeN) |-> lowCnt_q == 8'h10)
        else $error("drive length");
    a_gap_two: assert property (
        $rose(resetPinOeN) |-> resetPinOeN [*3])
        else $error("gap short");
    a_sysrst_pin: assert property (systemReset |-> !resetPinOeN)
        else $error("reset without pin");
    a_sysrst_len: assert property ($rose(systemReset) |->
        systemReset [*8] ##1 systemReset [*8] ##1 !systemReset)
        else $error("reset length");
    a_lock_drop: assert property (
        !vcoStable && clockMode != MODE_EXT_NOVCO |-> ##[0:5] !vcoLocked)
        else $error("lock kept");
    a_clk_toggles: assert property (
        clockMode != MODE_EXT_NOVCO |-> stillCnt_q < 8'h64)
        else $error("clock stalled");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read late");
    a_resp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("bresp dropped");
    a_rdata_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("rdata dropped");
    c_sysrst: cover property ($rose(systemReset));
    c_locked: cover property ($rose(vcoLocked));
    c_pin_only: cover property ($fell(resetPinOeN) && !systemReset);
endmodule : clock_synth_reset_control_sva

bind clock_synth_reset_control clock_synth_reset_control_sva i_sva (.*);

/* bench/reset_clock_partner.sv */
`timescale 1ns/100ps
module reset_clock_partner #(
    parameter int RefHalfNs = 80,
    parameter int VcoHalfNs = 24
) (
    output logic refClockInput,
    output logic vcoIn,
    output logic resetPinIn,
    input logic resetPinOeN,
    input logic resetPinOut,
    input logic extReq
);
    // Offsets keep source edges away from the sampling clock edge
    initial begin
        refClockInput = 1'b0;
        #5;
        forever #(RefHalfNs) refClockInput = ~refClockInput;
    end
    initial begin
        vcoIn = 1'b0;
        #3;
        forever #(VcoHalfNs) vcoIn = ~vcoIn;
    end
    // Pull-up restores the pin; only pull-downs can win
    assign resetPinIn = ((!resetPinOeN && !resetPinOut) || extReq) ?
        1'b0 : 1'b1;
endmodule : reset_clock_partner

/* bench/clock_synth_reset_control_test.sv */
`timescale 1ns/100ps
module clock_synth_reset_control_test;
    import clock_reset_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, vcoStable = 1'b0;
    logic operandBusy = 1'b0, cycleDone = 1'b0, lastPortion = 1'b0;
    logic extReq = 1'b0;
    logic watchdogReset = 1'b0, doubleBusFault = 1'b0, resetInstr = 1'b0;
    clock_mode_t clockMode = MODE_CRYSTAL;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic systemClockOutput, pumpUp, pumpDown, vcoLocked, systemReset;
    logic refClockInput, vcoIn, resetPinIn, resetPinOut, resetPinOeN;
    int err_count = 0, checks = 0, cycles = 0;
    always #(CLK_PERIOD_NS / 2) clock = ~clock;
    clock_synth_reset_control #(.LossCycles(200)) i_dut (.*);
    reset_clock_partner i_far (.*);
    // ========
    // Shared tasks
    task automatic complete_run;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check("bresp", (a > RESET_STAT_OFS) ? RESP_SLVERR : RESP_OKAY, bresp);
        bready <= 1'b0;
        @(posedge clock);
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        check("rresp", (a > RESET_STAT_OFS) ? RESP_SLVERR : RESP_OKAY, rresp);
        rready <= 1'b0;
        @(posedge clock);
    endtask : axi_read
    task automatic pulse(input logic [2:0] s);
        {resetInstr, doubleBusFault, watchdogReset} <= s;
        @(posedge clock);
        {resetInstr, doubleBusFault, watchdogReset} <= 3'h0;
    endtask : pulse
    task automatic watch(input int n, output int pinAt, output logic saw);
        pinAt = -1;
        saw = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            if (resetPinOeN === 1'b0 && pinAt < 0) pinAt = i;
            if (systemReset === 1'b1) saw = 1'b1;
        end
    endtask : watch
    task automatic period(output int p);
        int edges;
        logic prev;
        edges = 0;
        p = 0;
        prev = systemClockOutput;
        while (edges < 3 && p < 500) begin
            @(posedge clock);
            if (edges == 2) p++;
            if (systemClockOutput === 1'b1 && prev === 1'b0) edges++;
            prev = systemClockOutput;
        end
    endtask : period
    // ========
    // Scenarios
    task automatic t_defaults;
        logic [31:0] d;
        axi_read(SYNTH_CTRL_OFS, d);
        check("synth", {16'h0000, PRESCALE_RESET, POSTDIV_RESET, MULT_RESET,
            8'h00}, d & 32'h0000FF00);
        axi_read(RESET_STAT_OFS, d);
        check("stat", {26'h0, SRC_RESET}, d);
        axi_read(8'h0C, d);
        check("unmapped", 32'h00000000, d);
        axi_write(8'h0C, 32'hFFFFFFFF);
    endtask : t_defaults
    task automatic t_clock;
        int p;
        period(p);
        check("system_clock_output x0", 24, p);
        axi_write(SYNTH_CTRL_OFS, 32'h00007F00);
        period(p);
        check("system_clock_output x1", 12, p);
        clockMode <= MODE_EXT_NOVCO;
        period(p);
        check("system_clock_output ref", 20, p);
        clockMode <= MODE_CRYSTAL;
    endtask : t_clock
    task automatic t_defer;
        int pinAt;
        logic saw;
        logic [31:0] d;
        operandBusy <= 1'b1;
        pulse(3'h1);
        watch(12, pinAt, saw);
        check("held", 0, pinAt >= 0);
        cycleDone <= 1'b1;
        @(posedge clock);
        cycleDone <= 1'b0;
        watch(6, pinAt, saw);
        check("mid operand", 0, pinAt >= 0);
        {cycleDone, lastPortion} <= 2'h3;
        @(posedge clock);
        {cycleDone, lastPortion} <= 2'h0;
        watch(24, pinAt, saw);
        operandBusy <= 1'b0;
        check("operand end", 1, pinAt >= 0 && pinAt <= 4);
        check("wdog reset", 1, saw);
        axi_read(SYNTH_CTRL_OFS, d);
        check("synth cleared", 32'h00003F00, d & 32'h0000FF00);
        axi_read(RESET_STAT_OFS, d);
        check("wdog flag", 1, d[SRC_WDOG]);
    endtask : t_defer
    task automatic t_monitor;
        int pinAt;
        logic saw;
        for (int s = 0; s < 4; s++) begin
            axi_write(RESET_CTRL_OFS, 32'(s));
            operandBusy <= 1'b1;
            pulse(3'h2);
            watch(80, pinAt, saw);
            operandBusy <= 1'b0;
            check("monitor", 1, pinAt >= (64 >> s) - 2 &&
                pinAt <= (64 >> s) + 4);
            repeat (24) @(posedge clock);
        end
    endtask : t_monitor
    task automatic t_instr_ext;
        int pinAt;
        logic saw;
        logic [31:0] d;
        axi_write(SYNTH_CTRL_OFS, 32'h00007F00);
        pulse(3'h4);
        watch(24, pinAt, saw);
        check("instr pin", 1, pinAt >= 0);
        check("instr reset", 0, saw);
        axi_read(SYNTH_CTRL_OFS, d);
        check("kept synth", 32'h00007F00, d & 32'h0000FF00);
        extReq <= 1'b1;
        repeat (4) @(posedge clock);
        extReq <= 1'b0;
        watch(30, pinAt, saw);
        check("ext reset", 1, saw);
        axi_read(RESET_STAT_OFS, d);
        check("ext flag", 1, d[SRC_EXT]);
    endtask : t_instr_ext
    task automatic t_lock;
        int n;
        logic prev;
        n = 0;
        prev = refClockInput;
        vcoStable <= 1'b1;
        while (vcoLocked !== 1'b1 && n < 400) begin
            @(posedge clock);
            if (refClockInput && !prev) n++;
            prev = refClockInput;
        end
        check("lock edges", 1, n >= 328 && n <= 330);
        vcoStable <= 1'b0;
        repeat (8) @(posedge clock);
        check("unlocked", 0, vcoLocked);
    endtask : t_lock
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        t_defaults();
        t_clock();
        t_defer();
        t_monitor();
        t_instr_ext();
        t_lock();
        complete_run();
    end
endmodule : clock_synth_reset_control_test
